// ===== logic/pmc_pkg.sv
package pmc_pkg;

    // Register offsets (byte addresses in configuration space).
    localparam logic [7:0] OFF_PMHDR  = 8'h40;
    localparam logic [7:0] OFF_PMCSR  = 8'h44;
    localparam logic [7:0] OFF_MSI    = 8'h4C;

    // Capability header constants.
    localparam logic [7:0] PM_CAP_ID  = 8'h01;
    localparam logic [7:0] PM_NEXT    = 8'h4C;
    localparam logic [2:0] PM_REV     = 3'h3;
    localparam logic [7:0] MSI_CAP_ID = 8'h05;
    localparam logic [7:0] MSI_NEXT   = 8'h64;
    localparam logic [2:0] MSI_MMC    = 3'h2;
    localparam logic       MSI_A64    = 1'h1;

    // Field positions, header word at 40h.
    localparam int POS_ID   = 0;
    localparam int POS_NEXT = 8;
    localparam int POS_REV  = 16;
    localparam int POS_AUX  = 22;
    localparam int POS_D1   = 25;
    localparam int POS_D2   = 26;
    localparam int POS_PMES = 27;

    // Field positions, control/status word at 44h.
    localparam int POS_PS   = 0;
    localparam int POS_NSR  = 3;
    localparam int POS_PMEE = 8;
    localparam int POS_DSEL = 9;
    localparam int POS_DATA = 24;

    // Field positions, message control word at 4Ch.
    localparam int POS_MSIE = 16;
    localparam int POS_MMC  = 17;
    localparam int POS_MME  = 20;
    localparam int POS_A64  = 23;

    // Reset values.
    localparam logic [2:0] RST_AUX  = 3'h7;
    localparam logic       RST_D1   = 1'h1;
    localparam logic       RST_D2   = 1'h1;
    localparam logic [4:0] RST_PMES = 5'h1F;
    localparam logic       RST_NSR  = 1'h1;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [3:0] RST_DSEL = 4'h0;
    localparam logic [2:0] RST_MME  = 3'h0;

    // Power state encodings.
    localparam logic [1:0] PS_D0 = 2'h0;
    localparam logic [1:0] PS_D1 = 2'h1;
    localparam logic [1:0] PS_D2 = 2'h2;
    localparam logic [1:0] PS_D3 = 2'h3;

    typedef struct packed {
        logic [2:0] aux;
        logic       d1;
        logic       d2;
        logic [4:0] pmes;
        logic       nsr;
        logic [7:0] data;
    } pmc_pre_t;

    typedef struct packed {
        logic [1:0]  ps;
        logic        pme_en;
        logic [3:0]  dsel;
        logic        msi_en;
        logic        intx_en;
        logic [2:0]  mme;
        logic [31:0] rdata;
        logic        rvalid;
        logic        hot_rst;
        logic        int_rst;
        logic        dn_rst_n;
    } pmc_state_t;

endpackage

// ===== logic/pmc_preload.sv
`timescale 1ns/1ps

module pmc_preload (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    // Preload strobe and values
    input  wire logic       i_load,
    input  wire logic [2:0] i_aux,
    input  wire logic       i_d1,
    input  wire logic       i_d2,
    input  wire logic [4:0] i_pmes,
    input  wire logic       i_nsr,
    input  wire logic [7:0] i_data,
    // Current defaults
    output logic      [2:0] o_aux,
    output logic            o_d1,
    output logic            o_d2,
    output logic      [4:0] o_pmes,
    output logic            o_nsr,
    output logic      [7:0] o_data
);

    pmc_pkg::pmc_pre_t s_q;
    pmc_pkg::pmc_pre_t s_d;

    // A preload replaces all defaults at once, so a partly loaded set is never seen.
    always_comb begin
        s_d = s_q;
        if (i_load) begin
            s_d.aux  = i_aux;
            s_d.d1   = i_d1;
            s_d.d2   = i_d2;
            s_d.pmes = i_pmes;
            s_d.nsr  = i_nsr;
            s_d.data = i_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_q.aux  <= pmc_pkg::RST_AUX;
            s_q.d1   <= pmc_pkg::RST_D1;
            s_q.d2   <= pmc_pkg::RST_D2;
            s_q.pmes <= pmc_pkg::RST_PMES;
            s_q.nsr  <= pmc_pkg::RST_NSR;
            s_q.data <= pmc_pkg::RST_DATA;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_aux  = s_q.aux;
    assign o_d1   = s_q.d1;
    assign o_d2   = s_q.d2;
    assign o_pmes = s_q.pmes;
    assign o_nsr  = s_q.nsr;
    assign o_data = s_q.data;

endmodule

// ===== logic/pmc_regs.sv
`timescale 1ns/1ps
// Behaviour
// - Power management header byte 0 reads capability id 01h.
// - Power management header bits 15:8 read next pointer 4Ch.
// - Power management revision bits 18:16 read 011b.
// - Event clock, B2/B3 and bus power/clock enable bits read zero, ignore writes.
// - Device-specific-initialization bit 21 reads zero.
// - Auxiliary current bits 24:22 reset to 111b, preloadable.
// - D1 and D2 support bits read one by default, preloadable.
// - Wake-event support bits 31:27 read 11111b by default, preloadable.
// - Power state bits 1:0 read-write, reset D0, report current state.
// - Writing D0 from D3hot causes hot reset, downstream reset pin stays off.
// - No-internal-reset bit 3 resets one; when clear, D3hot-to-D0 resets internally.
// - Sticky power-event enable bit 8, reset zero, read-write.
// - Power event status bit 15 reads zero.
// - Data byte bits 31:24 read-only, reset 00h, preloadable.
// - Message interrupt header byte 0 reads capability id 05h.
// - Message interrupt next pointer reads 64h.
// - Message enable bit 16 resets zero; when set, legacy interrupts are forbidden.
// - Bit 23 reads one, 64-bit message address capable.

module pmc_regs #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_srst,
    // Configuration access
    input  wire logic              i_cfg_rd,
    input  wire logic              i_cfg_wr,
    input  wire logic [ADDR_W-1:0] i_cfg_addr,
    input  wire logic [3:0]        i_cfg_be,
    input  wire logic [31:0]       i_cfg_wdata,
    output logic      [31:0]       o_cfg_rdata,
    output logic                   o_cfg_rvalid,
    // Default preload
    input  wire logic              i_pre_load,
    input  wire logic [2:0]        i_pre_aux,
    input  wire logic              i_pre_d1,
    input  wire logic              i_pre_d2,
    input  wire logic [4:0]        i_pre_pmes,
    input  wire logic              i_pre_nsr,
    input  wire logic [7:0]        i_pre_data,
    // Block state
    output logic      [1:0]        o_power_state,
    output logic                   o_pme_en,
    output logic                   o_msi_en,
    output logic                   o_intx_en,
    output logic                   o_hot_reset,
    output logic                   o_internal_reset,
    output logic                   o_downstream_port_reset_out_n
);

    if (ADDR_W < 8) begin : g_chk
        $error("ADDR_W must be at least 8");
    end

    pmc_pkg::pmc_state_t s_q;
    pmc_pkg::pmc_state_t s_d;

    logic [2:0] pre_aux;
    logic       pre_d1;
    logic       pre_d2;
    logic [4:0] pre_pmes;
    logic       pre_nsr;
    logic [7:0] pre_data;

    pmc_preload u_pre (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .i_load (i_pre_load),
        .i_aux  (i_pre_aux),
        .i_d1   (i_pre_d1),
        .i_d2   (i_pre_d2),
        .i_pmes (i_pre_pmes),
        .i_nsr  (i_pre_nsr),
        .i_data (i_pre_data),
        .o_aux  (pre_aux),
        .o_d1   (pre_d1),
        .o_d2   (pre_d2),
        .o_pmes (pre_pmes),
        .o_nsr  (pre_nsr),
        .o_data (pre_data)
    );

    // Matches a dword offset; the two low address bits select bytes and are ignored.
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        logic [ADDR_W-1:0] o;
        o   = ADDR_W'(off);
        hit = (a[ADDR_W-1:2] == o[ADDR_W-1:2]);
    endfunction

    logic [31:0] rd_word;
    logic [1:0]  ps_new;
    logic        ps_ok;

    // Read data; every bit not set here reads zero.
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit(i_cfg_addr, pmc_pkg::OFF_PMHDR)) begin
            rd_word[pmc_pkg::POS_ID +: 8]   = pmc_pkg::PM_CAP_ID;
            rd_word[pmc_pkg::POS_NEXT +: 8] = pmc_pkg::PM_NEXT;
            rd_word[pmc_pkg::POS_REV +: 3]  = pmc_pkg::PM_REV;
            rd_word[pmc_pkg::POS_AUX +: 3]  = pre_aux;
            rd_word[pmc_pkg::POS_D1]        = pre_d1;
            rd_word[pmc_pkg::POS_D2]        = pre_d2;
            rd_word[pmc_pkg::POS_PMES +: 5] = pre_pmes;
        end else if (hit(i_cfg_addr, pmc_pkg::OFF_PMCSR)) begin
            rd_word[pmc_pkg::POS_PS +: 2]   = s_q.ps;
            rd_word[pmc_pkg::POS_NSR]       = pre_nsr;
            rd_word[pmc_pkg::POS_PMEE]      = s_q.pme_en;
            rd_word[pmc_pkg::POS_DSEL +: 4] = s_q.dsel;
            rd_word[pmc_pkg::POS_DATA +: 8] = pre_data;
        end else if (hit(i_cfg_addr, pmc_pkg::OFF_MSI)) begin
            rd_word[pmc_pkg::POS_ID +: 8]   = pmc_pkg::MSI_CAP_ID;
            rd_word[pmc_pkg::POS_NEXT +: 8] = pmc_pkg::MSI_NEXT;
            rd_word[pmc_pkg::POS_MSIE]      = s_q.msi_en;
            rd_word[pmc_pkg::POS_MMC +: 3]  = pmc_pkg::MSI_MMC;
            rd_word[pmc_pkg::POS_MME +: 3]  = s_q.mme;
            rd_word[pmc_pkg::POS_A64]       = pmc_pkg::MSI_A64;
        end
    end

    // A write of an unsupported D1 or D2 is dropped, so the field never claims
    // a state the device cannot be in.
    always_comb begin
        ps_new = i_cfg_wdata[pmc_pkg::POS_PS +: 2];
        ps_ok  = 1'h0;
        unique case (ps_new)
            pmc_pkg::PS_D0: ps_ok = 1'h1;
            pmc_pkg::PS_D1: ps_ok = pre_d1;
            pmc_pkg::PS_D2: ps_ok = pre_d2;
            pmc_pkg::PS_D3: ps_ok = 1'h1;
        endcase
    end

    always_comb begin
        s_d          = s_q;
        s_d.rvalid   = i_cfg_rd;
        s_d.rdata    = i_cfg_rd ? rd_word : s_q.rdata;
        s_d.hot_rst  = 1'h0;
        s_d.int_rst  = 1'h0;
        s_d.dn_rst_n = 1'h1;
        if (i_cfg_wr && hit(i_cfg_addr, pmc_pkg::OFF_PMCSR)) begin
            if (i_cfg_be[1]) begin
                s_d.pme_en = i_cfg_wdata[pmc_pkg::POS_PMEE];
                s_d.dsel   = i_cfg_wdata[pmc_pkg::POS_DSEL +: 4];
            end
            if (i_cfg_be[0] && ps_ok) begin
                s_d.ps = ps_new;
                if (s_q.ps == pmc_pkg::PS_D3 && ps_new == pmc_pkg::PS_D0) begin
                    s_d.hot_rst = 1'h1;
                    if (!pre_nsr) begin
                        // Internal reset spares the sticky enable and the state itself.
                        s_d.int_rst = 1'h1;
                        s_d.dsel    = pmc_pkg::RST_DSEL;
                        s_d.mme     = pmc_pkg::RST_MME;
                        s_d.msi_en  = 1'h0;
                        s_d.intx_en = 1'h1;
                    end
                end
            end
        end
        if (i_cfg_wr && hit(i_cfg_addr, pmc_pkg::OFF_MSI) && i_cfg_be[2]) begin
            s_d.msi_en  = i_cfg_wdata[pmc_pkg::POS_MSIE];
            s_d.intx_en = !i_cfg_wdata[pmc_pkg::POS_MSIE];
            s_d.mme     = i_cfg_wdata[pmc_pkg::POS_MME +: 3];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_q.ps       <= pmc_pkg::PS_D0;
            s_q.pme_en   <= 1'h0;
            s_q.dsel     <= pmc_pkg::RST_DSEL;
            s_q.msi_en   <= 1'h0;
            s_q.intx_en  <= 1'h1;
            s_q.mme      <= pmc_pkg::RST_MME;
            s_q.rdata    <= 32'h0000_0000;
            s_q.rvalid   <= 1'h0;
            s_q.hot_rst  <= 1'h0;
            s_q.int_rst  <= 1'h0;
            s_q.dn_rst_n <= 1'h1;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_cfg_rdata                   = s_q.rdata;
    assign o_cfg_rvalid                  = s_q.rvalid;
    assign o_power_state                 = s_q.ps;
    assign o_pme_en                      = s_q.pme_en;
    assign o_msi_en                      = s_q.msi_en;
    assign o_intx_en                     = s_q.intx_en;
    assign o_hot_reset                   = s_q.hot_rst;
    assign o_internal_reset              = s_q.int_rst;
    assign o_downstream_port_reset_out_n = s_q.dn_rst_n;

    a_pm_header: assert property (
        @(posedge i_clk) disable iff (i_srst)
        i_cfg_rd && hit(i_cfg_addr, pmc_pkg::OFF_PMHDR)
        |=> o_cfg_rvalid && o_cfg_rdata[21:0] == 22'h034C01)
        else $error("power management header id, pointer or revision wrong");

    a_pm_preload: assert property (
        @(posedge i_clk) disable iff (i_srst)
        i_cfg_rd && hit(i_cfg_addr, pmc_pkg::OFF_PMHDR)
        |=> o_cfg_rdata[31:22] == {$past(pre_pmes), $past(pre_d2), $past(pre_d1), $past(pre_aux)})
        else $error("power management capability bits do not follow defaults");

    a_csr_zeros: assert property (
        @(posedge i_clk) disable iff (i_srst)
        i_cfg_rd && hit(i_cfg_addr, pmc_pkg::OFF_PMCSR)
        |=> o_cfg_rdata[15:13] == 3'h0 && o_cfg_rdata[23:16] == 8'h00
            && o_cfg_rdata[7:4] == 4'h0 && o_cfg_rdata[2] == 1'h0)
        else $error("reserved or hardwired power control bits not zero");

    a_msi_header: assert property (
        @(posedge i_clk) disable iff (i_srst)
        i_cfg_rd && hit(i_cfg_addr, pmc_pkg::OFF_MSI)
        |=> o_cfg_rdata[15:0] == 16'h6405 && o_cfg_rdata[23] == 1'h1
            && o_cfg_rdata[31:24] == 8'h00)
        else $error("message interrupt header wrong");

    a_hot_reset: assert property (
        @(posedge i_clk) disable iff (i_srst)
        i_cfg_wr && hit(i_cfg_addr, pmc_pkg::OFF_PMCSR) && i_cfg_be[0]
            && o_power_state == 2'h3 && i_cfg_wdata[1:0] == 2'h0
        |=> o_hot_reset && o_power_state == 2'h0 && o_internal_reset == !$past(pre_nsr)
            ##1 !o_hot_reset)
        else $error("D3hot to D0 did not give a one-cycle hot reset");

    a_dn_reset_off: assert property (
        @(posedge i_clk) disable iff (i_srst)
        o_hot_reset |-> o_downstream_port_reset_out_n)
        else $error("downstream reset asserted by hot reset");

    a_irq_exclusive: assert property (
        @(posedge i_clk) disable iff (i_srst)
        o_msi_en != o_intx_en)
        else $error("message and legacy interrupts enabled together");

    a_ps_tracks: assert property (
        @(posedge i_clk) disable iff (i_srst)
        i_cfg_wr && hit(i_cfg_addr, pmc_pkg::OFF_PMCSR) && i_cfg_be[0]
            && (i_cfg_wdata[1:0] == 2'h0 || i_cfg_wdata[1:0] == 2'h3)
        |=> o_power_state == $past(i_cfg_wdata[1:0]))
        else $error("power state did not take written value");

    a_pme_sticky: assert property (
        @(posedge i_clk) disable iff (i_srst)
        o_internal_reset && !$past(i_cfg_wr && i_cfg_be[1]) |-> o_pme_en == $past(o_pme_en))
        else $error("power event enable lost on internal reset");

    // Only the D3hot to D0 step may pulse the hot reset.
    a_hot_only_d3: assert property (
        @(posedge i_clk) disable iff (i_srst)
        o_hot_reset |-> $past(o_power_state) == pmc_pkg::PS_D3 && o_power_state == pmc_pkg::PS_D0)
        else $error("hot reset without a D3hot to D0 step");

    a_ps_refused: assert property (
        @(posedge i_clk) disable iff (i_srst)
        i_cfg_wr && hit(i_cfg_addr, pmc_pkg::OFF_PMCSR) && i_cfg_be[0]
            && ((i_cfg_wdata[1:0] == pmc_pkg::PS_D1 && !pre_d1)
                || (i_cfg_wdata[1:0] == pmc_pkg::PS_D2 && !pre_d2))
        |=> $stable(o_power_state))
        else $error("power state entered a state whose support bit is clear");

    a_pme_write: assert property (
        @(posedge i_clk) disable iff (i_srst)
        i_cfg_wr && hit(i_cfg_addr, pmc_pkg::OFF_PMCSR) && i_cfg_be[1]
        |=> o_pme_en == $past(i_cfg_wdata[pmc_pkg::POS_PMEE]))
        else $error("power event enable did not take written value");

    a_msi_write: assert property (
        @(posedge i_clk) disable iff (i_srst)
        i_cfg_wr && hit(i_cfg_addr, pmc_pkg::OFF_MSI) && i_cfg_be[2]
        |=> o_msi_en == $past(i_cfg_wdata[pmc_pkg::POS_MSIE]))
        else $error("message enable did not take written value");

    // Defaults move only with a preload strobe; configuration writes never reach them.
    a_preload_hold: assert property (
        @(posedge i_clk) disable iff (i_srst)
        !i_pre_load |=> $stable(pre_data) && $stable(pre_nsr) && $stable(pre_aux))
        else $error("read-only default changed without a preload");

    a_unmapped_zero: assert property (
        @(posedge i_clk) disable iff (i_srst)
        i_cfg_rd && !hit(i_cfg_addr, pmc_pkg::OFF_PMHDR) && !hit(i_cfg_addr, pmc_pkg::OFF_PMCSR)
            && !hit(i_cfg_addr, pmc_pkg::OFF_MSI)
        |=> o_cfg_rvalid && o_cfg_rdata == 32'h0000_0000)
        else $error("unmapped read returned data");

    a_reset_values: assert property (
        @(posedge i_clk) disable iff (i_srst)
        $fell(i_srst) |-> o_power_state == pmc_pkg::PS_D0 && !o_pme_en && !o_msi_en && o_intx_en
            && !o_hot_reset && !o_cfg_rvalid)
        else $error("state not at reset values after reset");

endmodule

// ===== sim/pmc_host_model.sv
`timescale 1ns/1ps

module pmc_host_model #(
    parameter int ADDR_W = 8
) (
    // Clock
    input  wire logic              i_clk,
    // Configuration requests
    output logic                   o_cfg_rd,
    output logic                   o_cfg_wr,
    output logic      [ADDR_W-1:0] o_cfg_addr,
    output logic      [3:0]        o_cfg_be,
    output logic      [31:0]       o_cfg_wdata
);
    logic [31:0] exp_q[$];
    string       name_q[$];

    initial begin
        o_cfg_rd    = 1'h0;
        o_cfg_wr    = 1'h0;
        o_cfg_addr  = '0;
        o_cfg_be    = 4'h0;
        o_cfg_wdata = 32'h0;
    end

    // Released lines show the inverse of the last value, so a stale request can never look live.
    task automatic cfg_write(input logic [ADDR_W-1:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge i_clk);
        o_cfg_wr    = 1'h1;
        o_cfg_addr  = a;
        o_cfg_be    = be;
        o_cfg_wdata = d;
        @(negedge i_clk);
        o_cfg_wr    = 1'h0;
        o_cfg_addr  = ~a;
        o_cfg_be    = ~be;
        o_cfg_wdata = ~d;
    endtask

    task automatic cfg_read(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string n);
        @(negedge i_clk);
        o_cfg_rd   = 1'h1;
        o_cfg_addr = a;
        exp_q.push_back(e);
        name_q.push_back(n);
        @(negedge i_clk);
        o_cfg_rd   = 1'h0;
        o_cfg_addr = ~a;
    endtask
endmodule

// ===== sim/pmc_regs_tb.sv
`timescale 1ns/1ps

module pmc_regs_tb;
    logic        clk, srst, cfg_rd, cfg_wr, cfg_rvalid, pre_load, pre_d1, pre_d2, pre_nsr;
    logic [7:0]  cfg_addr, pre_data;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [2:0]  pre_aux;
    logic [4:0]  pre_pmes;
    logic [1:0]  power_state;
    logic        pme_en, msi_en, intx_en, hot_reset, internal_reset, dn_rst_n;
    int          error_cnt;
    int          checks_done;
    logic [1:0]  ps_m;
    logic        pme_m, msie_m, d1_m, d2_m, nsr_m;
    logic [3:0]  dsel_m;
    logic [2:0]  mme_m, aux_m;
    logic [4:0]  pmes_m;
    logic [7:0]  data_m;

    pmc_host_model #(.ADDR_W(8)) u_pmc_host_model (.i_clk(clk), .o_cfg_rd(cfg_rd), .o_cfg_wr(cfg_wr),
        .o_cfg_addr(cfg_addr), .o_cfg_be(cfg_be), .o_cfg_wdata(cfg_wdata));

    pmc_regs #(.ADDR_W(8)) u_pmc_regs (.i_clk(clk), .i_srst(srst), .i_cfg_rd(cfg_rd), .i_cfg_wr(cfg_wr),
        .i_cfg_addr(cfg_addr), .i_cfg_be(cfg_be), .i_cfg_wdata(cfg_wdata), .o_cfg_rdata(cfg_rdata),
        .o_cfg_rvalid(cfg_rvalid), .i_pre_load(pre_load), .i_pre_aux(pre_aux), .i_pre_d1(pre_d1),
        .i_pre_d2(pre_d2), .i_pre_pmes(pre_pmes), .i_pre_nsr(pre_nsr), .i_pre_data(pre_data),
        .o_power_state(power_state), .o_pme_en(pme_en), .o_msi_en(msi_en), .o_intx_en(intx_en),
        .o_hot_reset(hot_reset), .o_internal_reset(internal_reset), .o_downstream_port_reset_out_n(dn_rst_n));

    function automatic logic [31:0] exp40();
        return {pmes_m, d2_m, d1_m, aux_m, 3'h0, 3'h3, 8'h4C, 8'h01};
    endfunction

    function automatic logic [31:0] exp44();
        return {data_m, 8'h00, 1'h0, 2'h0, dsel_m, pme_m, 4'h0, nsr_m, 1'h0, ps_m};
    endfunction

    function automatic logic [31:0] exp4c();
        return {8'h00, 1'h1, mme_m, 3'h2, msie_m, 8'h64, 8'h05};
    endfunction

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] e);
        checks_done++;
        if (seen !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, seen);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic set_defaults();
        ps_m   = 2'h0;
        pme_m  = 1'h0;
        dsel_m = 4'h0;
        msie_m = 1'h0;
        mme_m  = 3'h0;
        aux_m  = 3'h7;
        d1_m   = 1'h1;
        d2_m   = 1'h1;
        pmes_m = 5'h1F;
        nsr_m  = 1'h1;
        data_m = 8'h00;
    endtask

    // A read that never answers is caught here rather than hanging the run.
    task automatic drain();
        for (int i = 0; i < 8 && u_pmc_host_model.exp_q.size() > 0; i++) begin
            @(negedge clk);
        end
        if (u_pmc_host_model.exp_q.size() > 0) begin
            check("read answer", 32'h0, 32'h1);
            stop_test();
        end
    endtask

    task automatic read_all();
        u_pmc_host_model.cfg_read(8'h40, exp40(), "pm header");
        u_pmc_host_model.cfg_read(8'h44, exp44(), "pm control");
        u_pmc_host_model.cfg_read(8'h4C, exp4c(), "msg control");
        drain();
    endtask

    task automatic pins(input logic hot, input logic intr);
        check("power_state", {30'h0, power_state}, {30'h0, ps_m});
        check("pme_en", {31'h0, pme_en}, {31'h0, pme_m});
        check("msi_en", {31'h0, msi_en}, {31'h0, msie_m});
        check("intx_en", {31'h0, intx_en}, {31'h0, ~msie_m});
        check("hot_reset", {31'h0, hot_reset}, {31'h0, hot});
        check("internal_reset", {31'h0, internal_reset}, {31'h0, intr});
        check("downstream_reset_n", {31'h0, dn_rst_n}, 32'h1);
    endtask

    always @(negedge clk) begin
        if (cfg_rvalid === 1'h1) begin
            if (u_pmc_host_model.exp_q.size() == 0) begin
                check("unrequested rvalid", 32'h1, 32'h0);
            end else begin
                check(u_pmc_host_model.name_q.pop_front(), cfg_rdata, u_pmc_host_model.exp_q.pop_front());
            end
        end
    end

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        srst = 1'h1; pre_load = 1'h0; pre_aux = 3'h7; pre_d1 = 1'h1; pre_d2 = 1'h1;
        pre_pmes = 5'h1F; pre_nsr = 1'h1; pre_data = 8'h00;
        error_cnt = 0;
        checks_done = 0;
        set_defaults();
        void'($urandom(32'h0dae));
        repeat (4) @(negedge clk);
        srst = 1'h0;
        read_all();
        u_pmc_host_model.cfg_read(8'h48, 32'h0, "unmapped read");
        drain();
        pins(1'h0, 1'h0);
        $display("test reset values done");
        u_pmc_host_model.cfg_write(8'h40, 4'hF, 32'hFFFFFFFF);
        u_pmc_host_model.cfg_write(8'h48, 4'hF, 32'hFFFFFFFF);
        u_pmc_host_model.cfg_write(8'h44, 4'hE, 32'hFFFFFFFF);
        pme_m  = 1'h1;
        dsel_m = 4'hF;
        read_all();
        u_pmc_host_model.cfg_read(8'h48, 32'h0, "unmapped after write");
        drain();
        $display("test read-only writes done");
        for (int s = 1; s < 5; s++) begin
            u_pmc_host_model.cfg_write(8'h44, 4'h1, {30'h3FFFFFFF, s[1:0]});
            ps_m = s[1:0];
            pins(s == 4, 1'h0);
            @(negedge clk);
            pins(1'h0, 1'h0);
            u_pmc_host_model.cfg_read(8'h44, exp44(), "power state");
        end
        drain();
        $display("test power states done");
        u_pmc_host_model.cfg_write(8'h4C, 4'h4, 32'hFFFFFFFF);
        msie_m = 1'h1;
        mme_m  = 3'h7;
        pins(1'h0, 1'h0);
        read_all();
        $display("test message enable done");
        @(negedge clk);
        pre_aux  = 3'($urandom);
        // D1 support is cleared on purpose so that the refused D1 write below is always exercised.
        pre_d1   = 1'h0;
        pre_d2   = 1'($urandom);
        pre_pmes = 5'($urandom);
        pre_data = 8'($urandom);
        pre_nsr  = 1'h0;
        pre_load = 1'h1;
        @(negedge clk);
        pre_load = 1'h0;
        aux_m = pre_aux; d1_m = pre_d1; d2_m = pre_d2; pmes_m = pre_pmes; data_m = pre_data; nsr_m = 1'h0;
        read_all();
        u_pmc_host_model.cfg_write(8'h44, 4'h1, 32'h00000001);
        u_pmc_host_model.cfg_write(8'h44, 4'h1, 32'h00000002);
        if (d2_m) begin
            ps_m = 2'h2;
        end
        u_pmc_host_model.cfg_read(8'h44, exp44(), "unsupported state");
        drain();
        u_pmc_host_model.cfg_write(8'h44, 4'h1, 32'h00000003);
        ps_m = 2'h3;
        u_pmc_host_model.cfg_write(8'h44, 4'h1, 32'h00000000);
        ps_m   = 2'h0;
        dsel_m = 4'h0;
        mme_m  = 3'h0;
        msie_m = 1'h0;
        pins(1'h1, 1'h1);
        read_all();
        $display("test preload and internal reset done");
        @(negedge clk);
        srst = 1'h1;
        repeat (2) @(negedge clk);
        srst = 1'h0;
        set_defaults();
        pins(1'h0, 1'h0);
        read_all();
        $display("test second reset done");
        stop_test();
    end
endmodule
